//--- fst_map.svh
/*
  Address map, field positions, reset values and limits of the fixed-stage
  thread initiation block.
  Assumes it is included by bare name from each design file that needs it.
*/
`ifndef FST_MAP_SVH
`define FST_MAP_SVH

// Stage indices into per-stage vectors
`define ST_VS        0
`define ST_GS        1
`define ST_CLIP      2
`define ST_SF        3
`define ST_WM        4
`define NUM_ST       5
`define ST_IDX_W     3

// Register offsets (byte addresses, one word each)
`define OFS_CTRL     8'h00
`define OFS_CAP0     8'h04
`define REG_STRIDE   8'h04
`define OFS_OBJ_GS   8'h18
`define OFS_OBJ_CLIP 8'h1c
`define OFS_OBJ_SF   8'h20
`define OFS_STATUS   8'h24
`define OFS_ACTIVE   8'h28

// Control register fields
`define CTRL_EN_LSB  0
`define CTRL_GEN_BIT 5
`define CTRL_CLIP_EN 6
`define CTRL_STRIP   7
`define CTRL_W       8

// Status register fields
`define STAT_PEND_LSB  0
`define STAT_STALL_LSB 5

// Reset values
`define CTRL_RST     8'h00
`define CAP_RST      6'h01
`define OBJ_RST      3'h3

// Thread and entry limits
`define CAP_W          6
`define OBJ_W          3
`define LATER_GS_CAP   6'h20
`define LATER_CLIP_CAP 6'h10
`define MAX_WRITERS    2'h2
`define VS_PAIR        3'h2
`define VS_SINGLE      3'h1
`define WM_ITEM        3'h1

`endif

//--- fst_pkg.sv
/*
  Types shared by the fixed-stage thread initiation design.
  Assumes nothing of its surroundings.
*/
package fst_pkg;

  typedef enum logic [2:0] {
    GATE_IDLE  = 3'b001,
    GATE_BUILD = 3'b010,
    GATE_REQ   = 3'b100
  } gate_state_t;

endpackage

//--- fst_regs.sv
/*
  Register bank of the fixed-stage thread initiation block.
  Assumes a plain single-cycle strobe port; read data follow one cycle later.
*/
`timescale 1ns/1ps
`include "fst_map.svh"

module fst_regs (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  // Register port
  input  wire logic [7:0]                addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [31:0]               rdata,
  // Configuration out
  output logic      [`CTRL_W-1:0]        ctrl,
  output logic      [`NUM_ST*`CAP_W-1:0] caps,
  output logic      [`OBJ_W-1:0]         obj_gs,
  output logic      [`OBJ_W-1:0]         obj_clip,
  output logic      [`OBJ_W-1:0]         obj_sf,
  // State in
  input  wire logic [`NUM_ST-1:0]        pending,
  input  wire logic [`NUM_ST-1:0]        stalled,
  input  wire logic [`NUM_ST*`CAP_W-1:0] active
);

  logic [`CTRL_W-1:0]        ctrl_ff, nxt_ctrl;
  logic [`NUM_ST*`CAP_W-1:0] caps_ff, nxt_caps;
  logic [`OBJ_W-1:0]         gs_ff, nxt_gs, clip_ff, nxt_clip, sf_ff, nxt_sf;
  logic [31:0]               rdata_ff, nxt_rdata;

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_caps  = caps_ff;
    nxt_gs    = gs_ff;
    nxt_clip  = clip_ff;
    nxt_sf    = sf_ff;
    nxt_rdata = 32'h0;
    if (wr) begin
      if (addr == `OFS_CTRL)     nxt_ctrl = wdata[`CTRL_W-1:0];
      if (addr == `OFS_OBJ_GS)   nxt_gs   = wdata[`OBJ_W-1:0];
      if (addr == `OFS_OBJ_CLIP) nxt_clip = wdata[`OBJ_W-1:0];
      if (addr == `OFS_OBJ_SF)   nxt_sf   = wdata[`OBJ_W-1:0];
    end
    for (int i = 0; i < `NUM_ST; i++) begin
      if (wr && addr == `OFS_CAP0 + 8'(i) * `REG_STRIDE) nxt_caps[i*`CAP_W +: `CAP_W] = wdata[`CAP_W-1:0];
      if (rd && addr == `OFS_CAP0 + 8'(i) * `REG_STRIDE) nxt_rdata = 32'(caps_ff[i*`CAP_W +: `CAP_W]);
    end
    // Unmapped reads return zero
    if (rd) begin
      case (addr)
        `OFS_CTRL:     nxt_rdata = 32'(ctrl_ff);
        `OFS_OBJ_GS:   nxt_rdata = 32'(gs_ff);
        `OFS_OBJ_CLIP: nxt_rdata = 32'(clip_ff);
        `OFS_OBJ_SF:   nxt_rdata = 32'(sf_ff);
        `OFS_STATUS:   nxt_rdata = 32'({stalled, pending});
        `OFS_ACTIVE:   nxt_rdata = 32'(active);
        default:       nxt_rdata = nxt_rdata;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff  <= `CTRL_RST;
      caps_ff  <= {`NUM_ST{`CAP_RST}};
      gs_ff    <= `OBJ_RST;
      clip_ff  <= `OBJ_RST;
      sf_ff    <= `OBJ_RST;
      rdata_ff <= 32'h0;
    end else if (ce) begin
      ctrl_ff  <= nxt_ctrl;
      caps_ff  <= nxt_caps;
      gs_ff    <= nxt_gs;
      clip_ff  <= nxt_clip;
      sf_ff    <= nxt_sf;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata    = rdata_ff;
  assign ctrl     = ctrl_ff;
  assign caps     = caps_ff;
  assign obj_gs   = gs_ff;
  assign obj_clip = clip_ff;
  assign obj_sf   = sf_ff;

endmodule

//--- fst_stage_gate.sv
/*
  Per-stage thread gate: checks input, output room, cap and hold, assembles
  the request for one cycle, presents it and counts executing threads.
  Assumes accept is high only while req is high, done one pulse per thread.
*/
`timescale 1ns/1ps
`include "fst_map.svh"

module fst_stage_gate #(
  parameter int CNT_W = `CAP_W
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Launch conditions
  input  wire logic             enable,
  input  wire logic             input_ok,
  input  wire logic             output_ok,
  input  wire logic [CNT_W-1:0] cap,
  input  wire logic             hold,
  // Dispatcher side
  output logic                  req,
  input  wire logic             accept,
  input  wire logic             done,
  // State
  output logic      [CNT_W-1:0] active
);

  fst_pkg::gate_state_t state_ff, nxt_state;
  logic [CNT_W-1:0]     active_ff, nxt_active;
  logic                 go;

  always_comb begin
    go         = enable && input_ok && output_ok && !hold && (active_ff < cap);
    nxt_state  = state_ff;
    nxt_active = active_ff;
    case (state_ff)
      fst_pkg::GATE_IDLE:  if (go) nxt_state = fst_pkg::GATE_BUILD;
      // Payload is assembled in full before the request is shown
      fst_pkg::GATE_BUILD: nxt_state = fst_pkg::GATE_REQ;
      fst_pkg::GATE_REQ:   if (accept) nxt_state = fst_pkg::GATE_IDLE;
      default:             nxt_state = fst_pkg::GATE_IDLE;
    endcase
    // Completions may come in any order, so only a count is kept
    if (state_ff == fst_pkg::GATE_REQ && accept) nxt_active = nxt_active + CNT_W'(1);
    if (done && active_ff != '0) nxt_active = nxt_active - CNT_W'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff  <= fst_pkg::GATE_IDLE;
      active_ff <= '0;
    end else if (ce) begin
      state_ff  <= nxt_state;
      active_ff <= nxt_active;
    end
  end

  assign req    = (state_ff == fst_pkg::GATE_REQ);
  assign active = active_ff;

  a_cap_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == fst_pkg::GATE_IDLE && ce && active_ff >= cap) |=> !req)
    else $error("request raised at thread cap");
  a_input_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == fst_pkg::GATE_IDLE && ce && !input_ok) |=> !req ##1 state_ff != fst_pkg::GATE_REQ)
    else $error("request raised without buffered input");
  a_output_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == fst_pkg::GATE_IDLE && ce && !output_ok) |=> state_ff == fst_pkg::GATE_IDLE)
    else $error("launch started without output entry");
  a_bypass_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == fst_pkg::GATE_IDLE && ce && !enable) |=> state_ff == fst_pkg::GATE_IDLE)
    else $error("disabled stage started a launch");
  a_hold_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == fst_pkg::GATE_IDLE && ce && hold) |=> !req)
    else $error("request raised while held");
  a_build_first: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(req) |-> $past(state_ff) == fst_pkg::GATE_BUILD)
    else $error("request raised before assembly");
  a_count_up: assert property (@(posedge ref_clk) disable iff (rst)
    (req && accept && ce && !done) |=> active_ff == $past(active_ff) + CNT_W'(1))
    else $error("accepted thread not counted");

endmodule

//--- fixed_stage_thread_initiation.sv
/*
  Thread initiation control for the thread-spawning fixed stages: input entry
  buffering, output entry checks, thread caps and a single request port to
  the shared thread dispatcher.
  Assumes the dispatcher acknowledges with disp_ack while disp_req is high,
  and reports every finished thread on thread_done of its stage.
*/
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "fst_map.svh"

module fixed_stage_thread_initiation #(
  parameter int BUF_W = 4
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // Incoming entries per stage
  input  wire logic [`NUM_ST-1:0]   entry_in,
  output logic      [`NUM_ST-1:0]   entry_ready,
  input  wire logic                 vs_flush,
  // Output entry state
  input  wire logic                 out_free_gs,
  input  wire logic                 out_free_clip,
  input  wire logic                 out_free_sf,
  input  wire logic                 out_done_gs,
  input  wire logic                 out_done_clip,
  input  wire logic                 wm_sb_hold,
  // Geometry entries released by the clipper
  output logic                      gs_rel_valid,
  output logic      [`OBJ_W-1:0]    gs_rel_count,
  // Thread dispatcher
  output logic                      disp_req,
  output logic      [`ST_IDX_W-1:0] disp_stage,
  output logic      [`OBJ_W-1:0]    disp_vtx_count,
  input  wire logic                 disp_ack,
  input  wire logic [`NUM_ST-1:0]   thread_done
);

  logic [`CTRL_W-1:0]        ctrl;
  logic [`NUM_ST*`CAP_W-1:0] caps, active_flat;
  logic [`OBJ_W-1:0]         obj_gs, obj_clip, obj_sf;
  logic [`NUM_ST-1:0]        stage_en, input_ok, output_ok, hold, accept, req;
  logic                      later_gen, clip_en, strip_mode;
  logic [`CAP_W-1:0]         cap_eff [`NUM_ST];
  logic [`OBJ_W-1:0]         need    [`NUM_ST];
  logic [BUF_W-1:0]          buf_ff  [`NUM_ST];
  logic [BUF_W-1:0]          nxt_buf [`NUM_ST];

  logic                 flush_ff, nxt_flush;
  logic                 cur_valid_ff, nxt_cur_valid;
  logic [`ST_IDX_W-1:0] cur_idx_ff, nxt_cur_idx;
  logic [`OBJ_W-1:0]    cur_cnt_ff, nxt_cur_cnt;
  logic [1:0]           gs_wr_ff, nxt_gs_wr, clip_wr_ff, nxt_clip_wr;
  logic [`OBJ_W-1:0]    retain_ff, nxt_retain, rel_cnt_ff, nxt_rel_cnt;
  logic                 rel_valid_ff, nxt_rel_valid;

  fst_regs u_regs (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .wr       (reg_wr),
    .rd       (reg_rd),
    .rdata    (reg_rdata),
    .ctrl     (ctrl),
    .caps     (caps),
    .obj_gs   (obj_gs),
    .obj_clip (obj_clip),
    .obj_sf   (obj_sf),
    .pending  (req),
    .stalled  (input_ok & ~output_ok),
    .active   (active_flat)
  );

  assign stage_en   = ctrl[`CTRL_EN_LSB +: `NUM_ST];
  assign later_gen  = ctrl[`CTRL_GEN_BIT];
  assign clip_en    = ctrl[`CTRL_CLIP_EN];
  assign strip_mode = ctrl[`CTRL_STRIP];

  // Launch conditions per stage
  always_comb begin
    for (int i = 0; i < `NUM_ST; i++) begin
      cap_eff[i] = caps[i*`CAP_W +: `CAP_W];
    end
    // Later generation bounds geometry and clip thread counts
    if (later_gen && cap_eff[`ST_GS] > `LATER_GS_CAP) cap_eff[`ST_GS] = `LATER_GS_CAP;
    if (later_gen && cap_eff[`ST_CLIP] > `LATER_CLIP_CAP) cap_eff[`ST_CLIP] = `LATER_CLIP_CAP;

    need[`ST_VS]   = (flush_ff && buf_ff[`ST_VS] < BUF_W'(`VS_PAIR)) ? `VS_SINGLE : `VS_PAIR;
    need[`ST_GS]   = (obj_gs == '0) ? `VS_SINGLE : obj_gs;
    need[`ST_CLIP] = (obj_clip == '0) ? `VS_SINGLE : obj_clip;
    need[`ST_SF]   = (obj_sf == '0) ? `VS_SINGLE : obj_sf;
    need[`ST_WM]   = `WM_ITEM;
    for (int i = 0; i < `NUM_ST; i++) begin
      input_ok[i] = buf_ff[i] >= BUF_W'(need[i]);
    end

    output_ok[`ST_VS]   = 1'b1;
    output_ok[`ST_GS]   = out_free_gs && !(later_gen && gs_wr_ff >= `MAX_WRITERS);
    output_ok[`ST_CLIP] = out_free_clip && !(later_gen && clip_wr_ff >= `MAX_WRITERS);
    output_ok[`ST_SF]   = out_free_sf;
    output_ok[`ST_WM]   = 1'b1;

    hold          = '0;
    hold[`ST_WM]  = wm_sb_hold;
  end

  // Command and fetch stages have no gate at all; only these five can spawn
  genvar g;
  generate
    for (g = 0; g < `NUM_ST; g++) begin : gen_gate
      assign accept[g] = disp_ack && cur_valid_ff && cur_idx_ff == `ST_IDX_W'(g);
      fst_stage_gate #(.CNT_W(`CAP_W)) u_gate (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .enable    (stage_en[g]),
        .input_ok  (input_ok[g]),
        .output_ok (output_ok[g]),
        .cap       (cap_eff[g]),
        .hold      (hold[g]),
        .req       (req[g]),
        .accept    (accept[g]),
        .done      (thread_done[g]),
        .active    (active_flat[g*`CAP_W +: `CAP_W])
      );
    end
  endgenerate

  // Input buffering; a bypassed stage passes entries straight on
  always_comb begin
    for (int i = 0; i < `NUM_ST; i++) begin
      entry_ready[i] = !stage_en[i] || buf_ff[i] != '1;
      nxt_buf[i]     = buf_ff[i];
      if (accept[i]) nxt_buf[i] = nxt_buf[i] - BUF_W'(cur_cnt_ff);
      if (entry_in[i] && stage_en[i] && buf_ff[i] != '1) nxt_buf[i] = nxt_buf[i] + BUF_W'(1);
    end
    nxt_flush = flush_ff;
    if (accept[`ST_VS] && cur_cnt_ff == `VS_SINGLE) nxt_flush = 1'b0;
    if (buf_ff[`ST_VS] == '0 && !entry_in[`ST_VS]) nxt_flush = 1'b0;
    if (vs_flush) nxt_flush = 1'b1;
  end

  // One request at a time goes out; the lowest stage index wins
  always_comb begin
    nxt_cur_valid = cur_valid_ff;
    nxt_cur_idx   = cur_idx_ff;
    nxt_cur_cnt   = cur_cnt_ff;
    if (cur_valid_ff && disp_ack) nxt_cur_valid = 1'b0;
    if (!cur_valid_ff) begin
      for (int i = `NUM_ST - 1; i >= 0; i--) begin
        if (req[i]) begin
          nxt_cur_valid = 1'b1;
          nxt_cur_idx   = `ST_IDX_W'(i);
          nxt_cur_cnt   = need[i];
        end
      end
    end
  end

  // Threads currently writing output entries
  always_comb begin
    nxt_gs_wr   = gs_wr_ff;
    nxt_clip_wr = clip_wr_ff;
    if (accept[`ST_GS]) nxt_gs_wr = nxt_gs_wr + 2'h1;
    if (out_done_gs && gs_wr_ff != '0) nxt_gs_wr = nxt_gs_wr - 2'h1;
    if (accept[`ST_CLIP]) nxt_clip_wr = nxt_clip_wr + 2'h1;
    if (out_done_clip && clip_wr_ff != '0) nxt_clip_wr = nxt_clip_wr - 2'h1;
  end

  // Strip and fan objects share vertices, so the previous object's entries
  // are only freed when the following object's clip thread is finished
  always_comb begin
    nxt_retain    = retain_ff;
    nxt_rel_valid = 1'b0;
    nxt_rel_cnt   = rel_cnt_ff;
    if (thread_done[`ST_CLIP] && clip_en) begin
      if (strip_mode) begin
        nxt_rel_valid = retain_ff != '0;
        nxt_rel_cnt   = retain_ff;
        nxt_retain    = obj_clip;
      end else begin
        nxt_rel_valid = 1'b1;
        nxt_rel_cnt   = obj_clip;
        nxt_retain    = '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < `NUM_ST; i++) buf_ff[i] <= '0;
      flush_ff     <= 1'b0;
      cur_valid_ff <= 1'b0;
      cur_idx_ff   <= '0;
      cur_cnt_ff   <= '0;
      gs_wr_ff     <= '0;
      clip_wr_ff   <= '0;
      retain_ff    <= '0;
      rel_valid_ff <= 1'b0;
      rel_cnt_ff   <= '0;
    end else if (ce) begin
      for (int i = 0; i < `NUM_ST; i++) buf_ff[i] <= nxt_buf[i];
      flush_ff     <= nxt_flush;
      cur_valid_ff <= nxt_cur_valid;
      cur_idx_ff   <= nxt_cur_idx;
      cur_cnt_ff   <= nxt_cur_cnt;
      gs_wr_ff     <= nxt_gs_wr;
      clip_wr_ff   <= nxt_clip_wr;
      retain_ff    <= nxt_retain;
      rel_valid_ff <= nxt_rel_valid;
      rel_cnt_ff   <= nxt_rel_cnt;
    end
  end

  assign disp_req       = cur_valid_ff;
  assign disp_stage     = cur_idx_ff;
  assign disp_vtx_count = cur_cnt_ff;
  assign gs_rel_valid   = rel_valid_ff;
  assign gs_rel_count   = rel_cnt_ff;

  a_gs_whole_obj: assert property (@(posedge ref_clk) disable iff (rst)
    (disp_req && disp_stage == `ST_IDX_W'(`ST_GS)) |-> buf_ff[`ST_GS] >= BUF_W'(disp_vtx_count))
    else $error("geometry request without whole object");
  a_vs_pair: assert property (@(posedge ref_clk) disable iff (rst)
    (disp_req && disp_stage == `ST_IDX_W'(`ST_VS) && !flush_ff) |-> disp_vtx_count == `VS_PAIR)
    else $error("vertex thread not paired without flush");
  a_gs_writers: assert property (@(posedge ref_clk) disable iff (rst)
    (later_gen && gs_wr_ff >= `MAX_WRITERS && ce) |=> !$rose(req[`ST_GS]) ##1 !$rose(req[`ST_GS]))
    else $error("third geometry writer started");
  a_clip_cap16: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(req[`ST_CLIP]) && $past(later_gen, 2) |-> $past(active_flat[`ST_CLIP*`CAP_W +: `CAP_W], 2) < `LATER_CLIP_CAP)
    else $error("clip thread above later limit");
  a_strip_release: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && thread_done[`ST_CLIP] && clip_en && strip_mode && retain_ff != '0) |=> gs_rel_count == $past(retain_ff))
    else $error("retained entries not released one object late");

endmodule

//--- disp_model.sv
/*
  Behavioural thread dispatcher that answers the initiation block.
  Assumes one request at a time and at most one thread per stage in flight.
*/
`timescale 1ns/1ps
`include "fst_map.svh"

module disp_model #(
  parameter int ACK_DLY  = 2,
  parameter int DONE_DLY = 20
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Dispatcher port
  input  wire logic                 disp_req,
  input  wire logic [`ST_IDX_W-1:0] disp_stage,
  output logic                      disp_ack,
  output logic      [`NUM_ST-1:0]   thread_done
);
  int wait_cnt;
  int tmr [`NUM_ST];

  always_ff @(posedge ref_clk) begin
    disp_ack    <= 1'b0;
    thread_done <= '0;
    if (rst) begin
      wait_cnt <= 0;
      for (int i = 0; i < `NUM_ST; i++) begin
        tmr[i] <= 0;
      end
    end else begin
      // Per-stage timers let threads finish in any order
      for (int i = 0; i < `NUM_ST; i++) begin
        if (tmr[i] == 1) thread_done[i] <= 1'b1;
        if (tmr[i] > 0) tmr[i] <= tmr[i] - 1;
      end
      // Ack only while the request stands
      if (disp_req && !disp_ack) begin
        if (wait_cnt == ACK_DLY) begin
          disp_ack        <= 1'b1;
          wait_cnt        <= 0;
          tmr[disp_stage] <= DONE_DLY;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule

//--- test_fixed_stage_thread_initiation.sv
/*
  Self-checking bench for the fixed-stage thread initiation block.
  Assumes the dispatcher model acks within a few cycles, threads last 20.
*/
`timescale 1ns/1ps
`include "fst_map.svh"

module test_fixed_stage_thread_initiation;
  logic        ref_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic [7:0]  reg_addr    = 8'h00;
  logic [31:0] reg_wdata   = 32'h0;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [4:0]  entry_in    = 5'h00;
  logic        vs_flush    = 1'b0;
  logic        out_free_sf = 1'b0;
  logic        wm_sb_hold  = 1'b0;
  logic        ce          = 1'b1;
  logic        out_free_gs = 1'b0;
  logic        out_done_gs = 1'b0;
  logic        gs_rel_valid;
  logic [2:0]  gs_rel_count;
  logic [2:0]  rel_last    = 3'h0;
  int          rel_seen    = 0;
  logic [31:0] reg_rdata;
  logic [4:0]  entry_ready;
  logic [4:0]  thread_done;
  logic [2:0]  disp_stage;
  logic [2:0]  disp_vtx_count;
  logic        disp_req;
  logic        disp_ack;
  logic [31:0] d;
  int          mismatches  = 0;
  int          tests_run   = 0;
  int          cyc         = 0;

  always #4 ref_clk = ~ref_clk;

  fixed_stage_thread_initiation #(.BUF_W(4)) i_fixed_stage_thread_initiation (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .entry_in(entry_in), .entry_ready(entry_ready), .vs_flush(vs_flush),
    .out_free_gs(out_free_gs), .out_free_clip(out_free_gs), .out_free_sf(out_free_sf),
    .out_done_gs(out_done_gs), .out_done_clip(1'b0), .wm_sb_hold(wm_sb_hold),
    .gs_rel_valid(gs_rel_valid), .gs_rel_count(gs_rel_count),
    .disp_req(disp_req), .disp_stage(disp_stage), .disp_vtx_count(disp_vtx_count),
    .disp_ack(disp_ack), .thread_done(thread_done)
  );

  disp_model i_disp_model (
    .ref_clk(ref_clk), .rst(rst), .disp_req(disp_req), .disp_stage(disp_stage),
    .disp_ack(disp_ack), .thread_done(thread_done)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic put(input logic [4:0] m);
    @(posedge ref_clk);
    entry_in <= m;
    @(posedge ref_clk);
    entry_in <= 5'h00;
  endtask

  // Counts released-entry pulses as the clipper hands geometry entries back
  always @(posedge ref_clk) begin
    if (gs_rel_valid === 1'b1) begin
      rel_seen++;
      rel_last = gs_rel_count;
    end
  end

  // Fails if any request shows up in the next n cycles
  task automatic quiet(input string nm, input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      #1 s = s | disp_req;
    end
    chk(nm, 32'h0, {31'h0, s});
  endtask

  task automatic get_req(input string nm, input logic [2:0] st, input logic [2:0] cnt);
    int n;
    n = 0;
    while (disp_req !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(nm, {25'h0, 1'b1, st, cnt}, {25'h0, disp_req, disp_stage, disp_vtx_count});
    while (disp_req === 1'b1 && n < 80) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask

  task automatic t_reset();
    chk("entry_ready", 32'h1f, {27'h0, entry_ready});
    rd(`OFS_CTRL, d);
    chk("ctrl", 32'h0, d);
    rd(`OFS_CAP0, d);
    chk("cap0", 32'h1, d);
    rd(`OFS_OBJ_SF, d);
    chk("obj_sf", 32'h3, d);
    rd(8'hfc, d);
    chk("unmapped", 32'h0, d);
    put(5'h1f);
    quiet("disabled req", 20);
    $display("test reset done");
  endtask

  task automatic t_wm();
    wr(`OFS_CTRL, 32'h10);
    wm_sb_hold <= 1'b1;
    put(5'h10);
    quiet("held req", 12);
    wm_sb_hold <= 1'b0;
    // No output room is free anywhere, the windower must not care
    get_req("wm req", 3'h4, 3'h1);
    rd(`OFS_ACTIVE, d);
    chk("wm active", 32'h01000000, d);
    put(5'h10);
    quiet("cap req", 8);
    get_req("wm req2", 3'h4, 3'h1);
    repeat (30) @(posedge ref_clk);
    $display("test windower done");
  endtask

  task automatic t_vs();
    wr(`OFS_CTRL, 32'h01);
    put(5'h01);
    quiet("vs single", 12);
    put(5'h01);
    get_req("vs pair", 3'h0, 3'h2);
    repeat (30) @(posedge ref_clk);
    put(5'h01);
    vs_flush <= 1'b1;
    @(posedge ref_clk);
    vs_flush <= 1'b0;
    get_req("vs flush", 3'h0, 3'h1);
    repeat (30) @(posedge ref_clk);
    $display("test vertex done");
  endtask

  task automatic t_sf();
    wr(`OFS_CTRL, 32'h08);
    wr(`OFS_OBJ_SF, 32'h2);
    put(5'h08);
    quiet("sf part obj", 10);
    put(5'h08);
    quiet("sf no room", 10);
    rd(`OFS_STATUS, d);
    chk("sf stalled", 32'h100, d);
    // Clock enable low must freeze the launch path even with room free
    ce          <= 1'b0;
    out_free_sf <= 1'b1;
    quiet("frozen req", 10);
    ce          <= 1'b1;
    get_req("sf req", 3'h3, 3'h2);
    $display("test setup done");
  endtask

  task automatic t_gs();
    wr(`OFS_CTRL, 32'h22);
    wr(`OFS_CAP0 + `REG_STRIDE, 32'h1);
    out_free_gs <= 1'b1;
    put(5'h02);
    put(5'h02);
    quiet("gs part obj", 10);
    out_free_gs <= 1'b0;
    put(5'h02);
    quiet("gs no room", 10);
    // Entry pool sized for the object and both writers, so room comes back
    out_free_gs <= 1'b1;
    get_req("gs req", 3'h1, 3'h3);
    repeat (30) @(posedge ref_clk);
    repeat (3) put(5'h02);
    get_req("gs req2", 3'h1, 3'h3);
    repeat (30) @(posedge ref_clk);
    repeat (3) put(5'h02);
    quiet("gs writers", 10);
    out_done_gs <= 1'b1;
    @(posedge ref_clk);
    out_done_gs <= 1'b0;
    get_req("gs req3", 3'h1, 3'h3);
    $display("test geometry done");
  endtask

  task automatic t_clip();
    wr(`OFS_CTRL, 32'hc4);
    repeat (2) begin
      repeat (3) put(5'h04);
      get_req("clip req", 3'h2, 3'h3);
    end
    repeat (30) @(posedge ref_clk);
    chk("gs_rel pulses", 32'h1, 32'(rel_seen));
    chk("gs_rel_count", 32'h3, {29'h0, rel_last});
    $display("test clip done");
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 t_reset();
    t_wm();
    t_vs();
    t_sf();
    t_gs();
    t_clip();
    results();
  end
endmodule
